// ---- rtl/rss_defines.svh ----
// Offsets, field positions, reset values and timing counts of the reset sequencer
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// Register byte offsets
`define RSS_OFF_STATUS   8'h00
`define RSS_OFF_WDOG     8'h04
`define RSS_OFF_CTRL     8'h08
`define RSS_OFF_PHASE    8'h0c

// Status bit positions
`define RSS_B_POR        7
`define RSS_B_EXT        6
`define RSS_B_WDOG       5
`define RSS_B_OPC        4
`define RSS_B_ADDR       3
`define RSS_B_MON        2
`define RSS_B_LOWV       1

// Control bit positions
`define RSS_B_STOP_EN    0
`define RSS_B_WDOG_EN    1

`define RSS_STATUS_POR   8'h82
`define RSS_CTRL_RST     8'h02
`define RSS_VECTOR_HI    16'hfffe
`define RSS_VECTOR_LO    16'hffff

// Timing: reference period and pin low time in ns, the other counts in reference clock cycles
`define RSS_REF_NS       20
`define RSS_STAB_CYC     4096
`define RSS_PIN_CYC      32
`define RSS_HOLD_CYC     32
`define RSS_T_RL_NS      100
`define RSS_T_RL_CYC     ((`RSS_T_RL_NS + `RSS_REF_NS - 1) / `RSS_REF_NS)

`define RSS_RESP_OKAY    2'b00
`define RSS_RESP_SLVERR  2'b10

`endif

// ---- rtl/rss_pkg.sv ----
// Types of the reset sequencer
package rss_pkg;

  typedef enum logic [2:0] {
    RSS_ST_RUN   = 3'h0,
    RSS_ST_DRIVE = 3'h1,
    RSS_ST_HOLD  = 3'h3,
    RSS_ST_STAB  = 3'h2,
    RSS_ST_LOWV  = 3'h6,
    RSS_ST_EXT   = 3'h7
  } rss_state_type;

  typedef struct packed {
    rss_state_type st;
    logic [12:0]   cnt;
    logic [19:0]   wdog;
    logic [3:0]    ext_cnt;
    logic          internal;
    logic [7:0]    status;
    logic [7:0]    ctrl;
    logic          aw_hold;
    logic [7:0]    aw_addr;
    logic          w_hold;
    logic [31:0]   w_data;
    logic          w_lane0;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic          cpu_reset;
    logic          clk_hold;
    logic          div4;
    logic          pin_oe;
    logic          vec_fetch;
    logic [15:0]   vec_addr;
  } rss_regs_type;

endpackage

// ---- rtl/rss_reset_sequencer.sv ----
// Reset sequencer with cause recording, watchdog and AXI4-Lite register access
`include "rss_defines.svh"

// Summary of operation
// - Any reset aborts running instruction immediately
// - CPU starts by fetching vector FFFE/FFFF
// - Every reset forces bus clock divide-by-four
// - Pin held low long enough: external reset
// - Internal reset drives pin low 32 cycles
// - Stay in reset 32 cycles after release
// - Power-on: clocks gated 4096 cycles, pin low
// - Pin released +32, CPU starts +64
// - Power-on sets power-on and low-supply flags only
// - Watchdog overflow resets and sets its flag
// - Any write to watchdog location restarts it
// - Low supply: pin low, then power-on timing
// - Unknown opcode resets, sets bad-opcode flag
// - Stop with stop disabled is bad opcode
// - Opcode fetch from unmapped address resets
// - Data access to unmapped address ignored
// - Status read-only, any read clears it
// - Flags accumulate until a read
// - Pin still low 32 after release: external
// - Forced monitor entry sets its flag
module rss_reset_sequencer
  import rss_pkg::*;
#(
  parameter int unsigned WDOG_LIMIT = 262144
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe,
  input  wire logic        supply_low,
  input  wire logic        bad_opcode,
  input  wire logic        stop_exec,
  input  wire logic        fetch_valid,
  input  wire logic        fetch_is_opcode,
  input  wire logic        fetch_unmapped,
  input  wire logic        monitor_force,
  output logic             cpu_reset,
  output logic             clk_hold,
  output logic             bus_clk_div4,
  output logic             vector_fetch,
  output logic [15:0]      vector_addr
);

  rss_regs_type cur_r;
  rss_regs_type cur_nxt;

  // Index 0..3 for a mapped word, 4 for unmapped
  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    case (addr)
      `RSS_OFF_STATUS: reg_index = 3'h0;
      `RSS_OFF_WDOG:   reg_index = 3'h1;
      `RSS_OFF_CTRL:   reg_index = 3'h2;
      `RSS_OFF_PHASE:  reg_index = 3'h3;
      default:         reg_index = 3'h4;
    endcase
  endfunction

  logic [7:0]  set_flags;
  logic        status_read;
  logic        wdog_kick;
  logic        cpu_cause;
  logic        ext_seen;
  logic [2:0]  w_idx;
  logic [2:0]  r_idx;

  always_comb
  begin
    cur_nxt     = cur_r;
    set_flags   = 8'h00;
    status_read = 1'b0;
    wdog_kick   = 1'b0;
    cpu_cause   = 1'b0;
    ext_seen    = 1'b0;
    w_idx       = reg_index(cur_r.aw_addr);
    r_idx       = reg_index(s_axi_araddr);
    cur_nxt.vec_fetch = 1'b0;

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && cur_r.awready)
    begin
      cur_nxt.aw_hold = 1'b1;
      cur_nxt.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && cur_r.wready)
    begin
      cur_nxt.w_hold  = 1'b1;
      cur_nxt.w_data  = s_axi_wdata;
      cur_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready)
      cur_nxt.bvalid = 1'b0;
    if (cur_r.aw_hold && cur_r.w_hold && !cur_r.bvalid)
    begin
      cur_nxt.aw_hold = 1'b0;
      cur_nxt.w_hold  = 1'b0;
      cur_nxt.bvalid  = 1'b1;
      cur_nxt.bresp   = `RSS_RESP_OKAY;
      case (w_idx)
        3'h1: wdog_kick = 1'b1; // Any value, any lanes
        3'h2:
        begin
          if (cur_r.w_lane0)
            cur_nxt.ctrl = cur_r.w_data[7:0];
        end
        3'h0, 3'h3: cur_nxt.bresp = `RSS_RESP_OKAY; // Read-only, write dropped
        default: cur_nxt.bresp = `RSS_RESP_SLVERR;
      endcase
    end
    cur_nxt.awready = !cur_nxt.aw_hold;
    cur_nxt.wready  = !cur_nxt.w_hold;

    // Read channel
    if (s_axi_rvalid && s_axi_rready)
    begin
      cur_nxt.rvalid  = 1'b0;
      cur_nxt.arready = 1'b1;
    end
    if (s_axi_arvalid && cur_r.arready)
    begin
      cur_nxt.arready = 1'b0;
      cur_nxt.rvalid  = 1'b1;
      cur_nxt.rresp   = `RSS_RESP_OKAY;
      cur_nxt.rdata   = 32'h0000_0000;
      case (r_idx)
        3'h0:
        begin
          cur_nxt.rdata[7:0] = {cur_r.status[7:1], 1'b0};
          status_read        = 1'b1;
        end
        3'h1: cur_nxt.rdata[19:0] = cur_r.wdog;
        3'h2: cur_nxt.rdata[7:0]  = cur_r.ctrl;
        3'h3: cur_nxt.rdata[2:0]  = cur_r.st;
        default: cur_nxt.rresp = `RSS_RESP_SLVERR;
      endcase
    end

    // Causes raised by the CPU only count while it runs
    if (cur_r.st == RSS_ST_RUN)
    begin
      if (bad_opcode || (stop_exec && !cur_r.ctrl[`RSS_B_STOP_EN]))
      begin
        set_flags[`RSS_B_OPC] = 1'b1;
        cpu_cause = 1'b1;
      end
      // Data accesses to holes are ignored here
      if (fetch_valid && fetch_is_opcode && fetch_unmapped)
      begin
        set_flags[`RSS_B_ADDR] = 1'b1;
        cpu_cause = 1'b1;
      end
      if (monitor_force)
      begin
        set_flags[`RSS_B_MON] = 1'b1;
        cpu_cause = 1'b1;
      end
      if (cur_r.ctrl[`RSS_B_WDOG_EN] &&
          cur_r.wdog == 20'(WDOG_LIMIT - 1) && !wdog_kick)
      begin
        set_flags[`RSS_B_WDOG] = 1'b1;
        cpu_cause = 1'b1;
      end
    end

    // Watchdog counts only while the CPU runs
    if (wdog_kick || cur_r.st != RSS_ST_RUN)
      cur_nxt.wdog = 20'h00000;
    else if (cur_r.ctrl[`RSS_B_WDOG_EN])
      cur_nxt.wdog = cur_r.wdog + 20'h00001;

    // Pin low filter, only when we are not driving it ourselves
    if (!rst_pin_i && !cur_r.pin_oe && cur_r.st == RSS_ST_RUN)
    begin
      if (cur_r.ext_cnt == 4'(`RSS_T_RL_CYC - 1))
        ext_seen = 1'b1;
      else
        cur_nxt.ext_cnt = cur_r.ext_cnt + 4'h1;
    end
    else
      cur_nxt.ext_cnt = 4'h0;

    cur_nxt.cnt = cur_r.cnt + 13'h0001;
    case (cur_r.st)
      RSS_ST_RUN:
      begin
        if (cpu_cause)
        begin
          cur_nxt.st       = RSS_ST_DRIVE;
          cur_nxt.cnt      = 13'h0000;
          cur_nxt.internal = 1'b1;
        end
        else if (ext_seen)
        begin
          set_flags[`RSS_B_EXT] = 1'b1;
          cur_nxt.st       = RSS_ST_EXT;
          cur_nxt.internal = 1'b0;
        end
      end
      RSS_ST_EXT:
      begin
        // Held until the outside party lets go
        if (rst_pin_i)
        begin
          cur_nxt.st  = RSS_ST_HOLD;
          cur_nxt.cnt = 13'h0000;
        end
      end
      RSS_ST_LOWV:
      begin
        if (!supply_low)
        begin
          cur_nxt.st  = RSS_ST_STAB;
          cur_nxt.cnt = 13'h0000;
        end
      end
      RSS_ST_STAB:
      begin
        if (cur_r.cnt == 13'(`RSS_STAB_CYC - 1))
        begin
          cur_nxt.st  = RSS_ST_DRIVE;
          cur_nxt.cnt = 13'h0000;
        end
      end
      RSS_ST_DRIVE:
      begin
        if (cur_r.cnt == 13'(`RSS_PIN_CYC - 1))
        begin
          cur_nxt.st  = RSS_ST_HOLD;
          cur_nxt.cnt = 13'h0000;
        end
      end
      RSS_ST_HOLD:
      begin
        if (cur_r.cnt == 13'(`RSS_HOLD_CYC - 1))
        begin
          cur_nxt.st        = RSS_ST_RUN;
          cur_nxt.vec_fetch = 1'b1;
          if (cur_r.internal && !rst_pin_i)
            set_flags[`RSS_B_EXT] = 1'b1;
        end
      end
      default:
      begin
        cur_nxt.st  = RSS_ST_STAB;
        cur_nxt.cnt = 13'h0000;
      end
    endcase

    // Low supply overrides every phase
    if (supply_low)
    begin
      set_flags[`RSS_B_LOWV] = 1'b1;
      cur_nxt.st       = RSS_ST_LOWV;
      cur_nxt.cnt      = 13'h0000;
      cur_nxt.internal = 1'b1;
    end

    // A set in the clearing cycle survives the clear
    cur_nxt.status = ((status_read ? 8'h00 : cur_r.status) | set_flags) & 8'hfe;

    cur_nxt.cpu_reset = (cur_nxt.st != RSS_ST_RUN);
    cur_nxt.div4      = (cur_nxt.st != RSS_ST_RUN);
    cur_nxt.clk_hold  = (cur_nxt.st == RSS_ST_STAB) ||
                        (cur_nxt.st == RSS_ST_LOWV);
    cur_nxt.pin_oe    = (cur_nxt.st == RSS_ST_STAB) ||
                        (cur_nxt.st == RSS_ST_LOWV) ||
                        (cur_nxt.st == RSS_ST_DRIVE);
    cur_nxt.vec_addr  = cur_nxt.vec_fetch ? `RSS_VECTOR_HI : cur_r.vec_addr;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Power-on: begin the stabilisation delay
      cur_r           <= '0;
      cur_r.st        <= RSS_ST_STAB;
      cur_r.status    <= `RSS_STATUS_POR;
      cur_r.ctrl      <= `RSS_CTRL_RST;
      cur_r.internal  <= 1'b1;
      cur_r.awready   <= 1'b1;
      cur_r.wready    <= 1'b1;
      cur_r.arready   <= 1'b1;
      cur_r.cpu_reset <= 1'b1;
      cur_r.clk_hold  <= 1'b1;
      cur_r.div4      <= 1'b1;
      cur_r.pin_oe    <= 1'b1;
      cur_r.vec_addr  <= `RSS_VECTOR_HI;
    end
    else
      cur_r <= cur_nxt;
  end

  assign s_axi_awready = cur_r.awready;
  assign s_axi_wready  = cur_r.wready;
  assign s_axi_bvalid  = cur_r.bvalid;
  assign s_axi_bresp   = cur_r.bresp;
  assign s_axi_arready = cur_r.arready;
  assign s_axi_rvalid  = cur_r.rvalid;
  assign s_axi_rdata   = cur_r.rdata;
  assign s_axi_rresp   = cur_r.rresp;
  // Open-drain: only ever pulls low
  assign rst_pin_o     = 1'b0;
  assign rst_pin_oe    = cur_r.pin_oe;
  assign cpu_reset     = cur_r.cpu_reset;
  assign clk_hold      = cur_r.clk_hold;
  assign bus_clk_div4  = cur_r.div4;
  assign vector_fetch  = cur_r.vec_fetch;
  assign vector_addr   = cur_r.vec_addr;

endmodule

// ---- test/rss_monitor.sv ----
// Checker of sequencing relations at the reset sequencer ports
module rss_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        rst_pin_i,
  input wire logic        rst_pin_oe,
  input wire logic        bad_opcode,
  input wire logic        monitor_force,
  input wire logic        cpu_reset,
  input wire logic        clk_hold,
  input wire logic        bus_clk_div4,
  input wire logic        vector_fetch,
  input wire logic [15:0] vector_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] oe_cnt_r;
  logic [15:0] hold_cnt_r;
  logic [15:0] rel_cnt_r;
  logic        drove_r;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Runs of 32 and more are too long for a repetition
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      oe_cnt_r   <= 16'h0;
      hold_cnt_r <= 16'h0;
      rel_cnt_r  <= 16'h0;
      drove_r    <= 1'b1;
    end
    else
    begin
      oe_cnt_r   <= rst_pin_oe ? oe_cnt_r + 16'h1 : 16'h0;
      hold_cnt_r <= (cpu_reset && !rst_pin_oe && rst_pin_i) ? hold_cnt_r + 16'h1 : 16'h0;
      // Hold after our own drive counts whatever level others keep on the pin
      rel_cnt_r  <= (cpu_reset && !rst_pin_oe) ? rel_cnt_r + 16'h1 : 16'h0;
      drove_r    <= cpu_reset ? (drove_r || rst_pin_oe) : 1'b0;
    end
  end
  a_cause_resets: assert property (!cpu_reset && (bad_opcode || monitor_force) |=> cpu_reset && rst_pin_oe)
    else $error("cause did not start a reset");
  a_pin_drive: assert property ($fell(rst_pin_oe) && oe_cnt_r < 16'h64 |-> oe_cnt_r == 16'h20)
    else $error("pin driven for wrong count");
  a_hold_count: assert property ($fell(cpu_reset) && drove_r |-> rel_cnt_r == 16'h20)
    else $error("hold after pin release wrong");
  // External: one cycle to see the pin high, then the 32 cycle hold
  a_ext_hold: assert property ($fell(cpu_reset) && !drove_r |-> hold_cnt_r == 16'h21)
    else $error("hold after external reset wrong");
  a_vector_pulse: assert property ($fell(cpu_reset) |-> vector_fetch && vector_addr == 16'hfffe ##1 !vector_fetch)
    else $error("vector fetch pulse wrong");
  a_div_four: assert property (cpu_reset |-> bus_clk_div4)
    else $error("bus clock not divided by four");
  a_gate_pin: assert property (clk_hold |-> rst_pin_oe && cpu_reset)
    else $error("clock gated without pin and reset");
  a_stab_release: assert property ($fell(clk_hold) |-> ##31 rst_pin_oe ##1 !rst_pin_oe ##31 cpu_reset ##1 !cpu_reset)
    else $error("release timing after stabilisation wrong");
  a_ext_reset: assert property ((!cpu_reset && !rst_pin_oe && !rst_pin_i) [*5] |-> ##[1:3] cpu_reset)
    else $error("low pin did not reset");
  c_stab: cover property ($fell(clk_hold));
  c_internal: cover property ($rose(rst_pin_oe) && !clk_hold);
  c_start: cover property ($fell(cpu_reset));
endmodule

bind rss_reset_sequencer rss_checker rss_checker_i (
  .aclk(aclk), .aresetn(aresetn), .rst_pin_i(rst_pin_i), .rst_pin_oe(rst_pin_oe),
  .bad_opcode(bad_opcode), .monitor_force(monitor_force), .cpu_reset(cpu_reset),
  .clk_hold(clk_hold), .bus_clk_div4(bus_clk_div4), .vector_fetch(vector_fetch),
  .vector_addr(vector_addr));

// ---- test/rss_far_end.sv ----
// Shared reset line: pull-up, open-drain device side and an outside party
module rss_far_end (
  input  wire logic rst_pin_o,
  input  wire logic rst_pin_oe,
  input  wire logic ext_low,
  output logic      rst_pin_i
);
  timeunit 1ns;
  timeprecision 1ps;
  // Pull-up wins only while nobody pulls down
  assign rst_pin_i = rst_pin_oe ? rst_pin_o : !ext_low;
endmodule

// ---- test/tb_reset_sequencer_status.sv ----
// Self-checking bench of the reset sequencer
`include "rss_defines.svh"
module tb_reset_sequencer_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        supply_low = 1'b0;
  logic        bad_opcode = 1'b0;
  logic        stop_exec = 1'b0;
  logic        fetch_valid = 1'b0;
  logic        fetch_is_opcode = 1'b0;
  logic        fetch_unmapped = 1'b0;
  logic        monitor_force = 1'b0;
  logic        ext_low = 1'b0;
  logic [31:0] s_axi_rdata, rd_data;
  logic [15:0] vector_addr;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rst_pin_i, rst_pin_o, rst_pin_oe, cpu_reset, clk_hold, bus_clk_div4, vector_fetch;
  logic [31:0] exp_tab [5] = '{32'h10, 32'h10, 32'h08, 32'h04, 32'h20};
  int          err_count = 0;
  int          comparisons = 0;

  rss_reset_sequencer #(.WDOG_LIMIT(64)) rss_reset_sequencer_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .rst_pin_i(rst_pin_i), .rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .supply_low(supply_low),
    .bad_opcode(bad_opcode), .stop_exec(stop_exec), .fetch_valid(fetch_valid),
    .fetch_is_opcode(fetch_is_opcode), .fetch_unmapped(fetch_unmapped), .monitor_force(monitor_force),
    .cpu_reset(cpu_reset), .clk_hold(clk_hold), .bus_clk_div4(bus_clk_div4),
    .vector_fetch(vector_fetch), .vector_addr(vector_addr));
  rss_far_end rss_far_end_i (.rst_pin_o(rst_pin_o), .rst_pin_oe(rst_pin_oe), .ext_low(ext_low),
    .rst_pin_i(rst_pin_i));

  initial forever #10 aclk = ~aclk;

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd_data = s_axi_rdata;
    rd_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd_stat(input logic [31:0] e, input string s);
    axi_rd(`RSS_OFF_STATUS);
    chk(s, e, rd_data);
    $display("test %s done", s);
  endtask

  task automatic fire(input int c);
    case (c)
      0: bad_opcode <= 1'b1;
      1: stop_exec <= 1'b1;
      2: fetch_is_opcode <= 1'b1;
      3: monitor_force <= 1'b1;
      4: axi_wr(`RSS_OFF_CTRL, 32'h2);
      default: fetch_is_opcode <= 1'b0;
    endcase
    fetch_valid    <= (c == 2 || c == 5);
    fetch_unmapped <= (c == 2 || c == 5);
    @(posedge aclk);
    {bad_opcode, stop_exec, fetch_is_opcode, monitor_force, fetch_valid, fetch_unmapped} <= 6'h00;
  endtask

  // Counts are taken from values sampled at each edge; a negative figure skips that count
  task automatic run_seq(input int oe_exp, input int hold_exp, input bit stab);
    int n_oe = 0;
    int n_hold = 0;
    int n_clk = 0;
    int k = 0;
    bit seen = 1'b0;
    while (!(seen && !cpu_reset) && k < 9000)
    begin
      @(posedge aclk);
      k++;
      seen |= cpu_reset;
      n_oe += int'(cpu_reset && rst_pin_oe);
      n_hold += int'(cpu_reset && !rst_pin_oe && rst_pin_i);
      n_clk += int'(clk_hold);
    end
    chk("vector fetch", 32'h1, {31'h0, vector_fetch});
    chk("vector addr", 32'hfffe, {16'h0, vector_addr});
    if (oe_exp >= 0) chk("pin low cycles", oe_exp, n_oe);
    if (hold_exp >= 0) chk("hold cycles", hold_exp, n_hold);
    if (stab) chk("clock gate", 32'h1, {31'h0, n_clk inside {[4096:4098]}});
    // Watchdog enable is set at power-on and by the watchdog case; stop it before it fires unasked
    axi_wr(`RSS_OFF_CTRL, 32'h0);
  endtask

  task automatic print_verdict();
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge aclk);
    err_count++;
    print_verdict();
  end

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    run_seq(-1, 32, 1);
    rd_stat(32'h82, "power-on status");
    rd_stat(32'h0, "status cleared by read");
    axi_wr(`RSS_OFF_STATUS, 32'hff);
    chk("status write resp", 32'h0, {30'h0, wr_resp});
    rd_stat(32'h0, "status read-only");
    axi_rd(8'h10);
    chk("unmapped resp", 32'h2, {30'h0, rd_resp});
    axi_wr(8'h10, 32'h1);
    chk("unmapped write resp", 32'h2, {30'h0, wr_resp});
    for (int c = 0; c < 5; c++)
    begin
      fire(c);
      run_seq(32, 32, 0);
      rd_stat(exp_tab[c], "cause flag");
    end
    fire(5);
    repeat (8) @(posedge aclk);
    chk("no reset on data fetch", 32'h0, {31'h0, cpu_reset});
    rd_stat(32'h0, "data fetch");
    fire(0);
    run_seq(32, 32, 0);
    fire(3);
    run_seq(32, 32, 0);
    rd_stat(32'h14, "accumulated flags");
    ext_low <= 1'b1;
    fork
      // One cycle to see the pin high, then the 32 cycle hold
      run_seq(-1, 33, 0);
      begin
        repeat (10) @(posedge aclk);
        ext_low <= 1'b0;
      end
    join
    rd_stat(32'h40, "external reset");
    fire(0);
    ext_low <= 1'b1;
    fork
      run_seq(32, -1, 0);
      begin
        repeat (80) @(posedge aclk);
        ext_low <= 1'b0;
      end
    join
    rd_stat(32'h50, "pin low after release");
    supply_low <= 1'b1;
    repeat (10) @(posedge aclk);
    supply_low <= 1'b0;
    run_seq(-1, 32, 1);
    rd_stat(32'h02, "low supply");
    axi_wr(`RSS_OFF_WDOG, 32'h0);
    axi_wr(`RSS_OFF_CTRL, 32'h2);
    for (int i = 0; i < 5; i++)
    begin
      repeat (40) @(posedge aclk);
      axi_wr(`RSS_OFF_WDOG, 32'ha5 + i);
    end
    chk("running after kicks", 32'h0, {31'h0, cpu_reset});
    axi_wr(`RSS_OFF_CTRL, 32'h0);
    rd_stat(32'h0, "watchdog kick");
    print_verdict();
  end
endmodule
